/* common/idr_pkg.sv */
// package: constants, config indices and state struct for irq/dma routing
package idr_pkg;
    localparam int         DEV_COUNT      = 6;
    localparam int         IRQ_LINES      = 16;
    localparam int         DMA_LINES      = 4;
    localparam int         DEV_FLOPPY     = 0;
    localparam int         DEV_PARALLEL   = 3;
    localparam int         DEV_UART_A     = 4;
    localparam int         DEV_UART_B     = 5;
    // configuration register indices and strap port addresses
    localparam logic [7:0] IDX_LDN        = 8'h07;
    localparam logic [7:0] IDX_OSC        = 8'h24;
    localparam logic [7:0] IDX_PORT_LO    = 8'h26;
    localparam logic [7:0] IDX_PORT_HI    = 8'h27;
    localparam logic [7:0] IDX_ACTIVATE   = 8'h30;
    localparam logic [7:0] IDX_BASE_HI    = 8'h60;
    localparam logic [7:0] IDX_BASE_LO    = 8'h61;
    localparam logic [7:0] IDX_IRQ_SEL    = 8'h70;
    localparam logic [7:0] IDX_DMA_SEL    = 8'h74;
    localparam logic [15:0] PORT_STRAP_LO = 16'h002e;
    localparam logic [15:0] PORT_STRAP_HI = 16'h004e;
    // reset values
    localparam logic [7:0] IRQ_RST_FLOPPY = 8'h06;
    localparam logic [7:0] IRQ_RST_OTHER  = 8'h00;
    localparam logic [7:0] DMA_RST_FLOPPY = 8'h02;
    localparam logic [7:0] DMA_RST_PP_SER = 8'h04;
    localparam logic [7:0] DMA_RST_OTHER  = 8'h00;
    // field positions and ecr mode codes
    localparam int         OSC_QUAL_BIT   = 6;
    localparam int         ACT_BIT        = 0;
    localparam int         DOR_DMA_BIT    = 3;
    localparam int         CTRL_PARALLEL_IRQ_GATE_BIT  = 4;
    localparam int         ECR_SVC_BIT    = 2;
    localparam int         ECR_FLOPPY_DMA_GATE_BIT  = 3;
    localparam int         ECR_MODE_LSB   = 5;
    localparam int         MCR_UART_AUX_OUTPUT_TWO_BIT   = 2;
    localparam logic [2:0] MODE_FIFO      = 3'h2;
    localparam logic [2:0] MODE_ECP       = 3'h3;
    localparam logic [2:0] MODE_TEST      = 3'h6;

    typedef enum logic [1:0] {
        IDR_ST_STRAP = 2'b01,
        IDR_ST_RUN   = 2'b10
    } idr_phase_t;

    typedef struct packed {
        logic [DEV_COUNT-1:0] [7:0] irq_sel;
        logic [DEV_COUNT-1:0] [7:0] dma_sel;
        logic [DEV_COUNT-1:0] [7:0] act;
        logic [DEV_COUNT-1:0] [7:0] base_hi;
        logic [DEV_COUNT-1:0] [7:0] base_lo;
        logic [7:0]                 idx;
        logic [7:0]                 ldn;
        logic [7:0]                 osc_cfg;
        logic [15:0]                port;
        logic [7:0]                 rdata;
        idr_phase_t                 phase;
    } idr_state_t;

    typedef struct packed {
        logic [7:0] floppy_digital_output_reg;
        logic       powered_down;
        logic       irq;
        logic       drq;
    } idr_floppy_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] ecr;
        logic       ecp_mode;
        logic       epp_mode;
        logic       irq;
        logic       drq;
    } idr_parallel_t;

    typedef struct packed {
        logic [7:0] uart_interrupt_enable_reg;
        logic [7:0] modem_control_reg;
        logic       irq;
    } idr_uart_t;
endpackage

/* hw/idr_router.sv */
// module: configuration port, base decode and irq/dma routing for devices
`timescale 1ns/1ps
module idr_router
    import idr_pkg::*;
#(
    parameter logic [IRQ_LINES-1:0] PIN_IRQ_MASK = 16'hffff
) (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  soft_rst,
    input  wire logic                  config_port_strap,
    input  wire logic [15:0]           io_addr,
    input  wire logic                  io_wr,
    input  wire logic                  io_rd,
    input  wire logic [7:0]            io_wdata,
    output logic      [7:0]            io_rdata,
    output logic      [DEV_COUNT-1:0]  dev_addr_hit,
    input  wire idr_floppy_t           floppy_controller,
    input  wire idr_parallel_t         parallel_port,
    input  wire idr_uart_t             uart_a,
    input  wire idr_uart_t             uart_b,
    input  wire logic                  serial_irq_mode,
    input  wire logic                  smi_enable,
    input  wire logic                  smi_request,
    output logic                       system_mgmt_interrupt_n,
    output logic      [IRQ_LINES-1:0]  irq_out,
    output logic      [IRQ_LINES-1:0]  irq_oe_n,
    output logic      [DMA_LINES-1:0]  dma_req,
    output logic      [DMA_LINES-1:0]  dma_oe_n,
    input  wire logic [DMA_LINES-1:0]  dma_ack,
    output logic                       floppy_dma_ack,
    output logic                       parallel_dma_ack
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] irq_reset_value(input int dev);
        irq_reset_value = (dev == DEV_FLOPPY) ? IRQ_RST_FLOPPY
                                              : IRQ_RST_OTHER;
    endfunction

    function automatic logic [7:0] dma_reset_value(input int dev);
        if (dev == DEV_FLOPPY) begin
            dma_reset_value = DMA_RST_FLOPPY;
        end else if (dev == DEV_PARALLEL || dev == DEV_UART_B) begin
            dma_reset_value = DMA_RST_PP_SER;
        end else begin
            dma_reset_value = DMA_RST_OTHER;
        end
    endfunction

    // dma select decodes to a channel only for 1..3; 0 and 4..7 mean none
    function automatic logic [DMA_LINES-1:0] dma_decode(input logic [7:0] s);
        dma_decode = '0;
        if (s[2:0] >= 3'h1 && s[2:0] <= 3'h3) begin
            dma_decode[s[1:0]] = 1'b1;
        end
    endfunction

    function automatic logic [IRQ_LINES-1:0] irq_decode(input logic [7:0] s);
        irq_decode = '0;
        if (s[3:0] != 4'h0) begin
            irq_decode[s[3:0]] = 1'b1;
        end
    endfunction

    // reset image is worked out at elaboration, so the asynchronous
    // reset branch loads one constant and nothing computed at run time
    function automatic idr_state_t reset_image();
        reset_image       = '0;
        reset_image.phase = IDR_ST_STRAP;
        reset_image.port  = PORT_STRAP_LO;
        for (int d = 0; d < DEV_COUNT; d++) begin
            reset_image.irq_sel[d] = irq_reset_value(d);
            reset_image.dma_sel[d] = dma_reset_value(d);
        end
    endfunction

    localparam idr_state_t ST_RESET = reset_image();

    ////////////////////////////////////////////////////////////////////////
    // configuration state

    idr_state_t st_r;
    idr_state_t st_nxt;
    logic       port_idx_hit;
    logic       port_data_hit;

    // exact sixteen-bit compare, as a relocated port may sit anywhere
    assign port_idx_hit  = (io_addr == st_r.port);
    assign port_data_hit = (io_addr == st_r.port + 16'h0001);

    always_comb begin
        st_nxt = st_r;
        case (st_r.phase)
            IDR_ST_STRAP: begin
                // strap is caught after reset release, never under reset
                st_nxt.port  = config_port_strap ? PORT_STRAP_HI
                                                 : PORT_STRAP_LO;
                st_nxt.phase = IDR_ST_RUN;
            end
            IDR_ST_RUN: begin
                if (io_wr && port_idx_hit) begin
                    st_nxt.idx = io_wdata;
                end else if (io_wr && port_data_hit) begin
                    case (st_r.idx)
                        IDX_LDN:     st_nxt.ldn     = io_wdata;
                        IDX_OSC:     st_nxt.osc_cfg = io_wdata;
                        IDX_PORT_LO: st_nxt.port[7:0]  = io_wdata;
                        IDX_PORT_HI: st_nxt.port[15:8] = io_wdata;
                        default: begin
                            if (st_r.ldn < 8'(DEV_COUNT)) begin
                                case (st_r.idx)
                                    IDX_ACTIVATE:
                                        st_nxt.act[st_r.ldn] = io_wdata;
                                    IDX_BASE_HI:
                                        st_nxt.base_hi[st_r.ldn] = io_wdata;
                                    IDX_BASE_LO:
                                        st_nxt.base_lo[st_r.ldn] = io_wdata;
                                    IDX_IRQ_SEL:
                                        st_nxt.irq_sel[st_r.ldn] =
                                            io_wdata;
                                    IDX_DMA_SEL:
                                        st_nxt.dma_sel[st_r.ldn] =
                                            io_wdata;
                                    default: ;
                                endcase
                            end
                        end
                    endcase
                end
            end
            default: st_nxt.phase = IDR_ST_STRAP;
        endcase

        // read data is registered; unmapped indices read as zero
        if (io_rd && port_idx_hit) begin
            st_nxt.rdata = st_r.idx;
        end else if (io_rd && port_data_hit) begin
            case (st_r.idx)
                IDX_LDN:     st_nxt.rdata = st_r.ldn;
                IDX_OSC:     st_nxt.rdata = st_r.osc_cfg;
                IDX_PORT_LO: st_nxt.rdata = st_r.port[7:0];
                IDX_PORT_HI: st_nxt.rdata = st_r.port[15:8];
                default: begin
                    st_nxt.rdata = 8'h00;
                    if (st_r.ldn < 8'(DEV_COUNT)) begin
                        case (st_r.idx)
                            IDX_ACTIVATE: st_nxt.rdata = st_r.act[st_r.ldn];
                            IDX_BASE_HI:
                                st_nxt.rdata = st_r.base_hi[st_r.ldn];
                            IDX_BASE_LO:
                                st_nxt.rdata = st_r.base_lo[st_r.ldn];
                            IDX_IRQ_SEL:
                                st_nxt.rdata = st_r.irq_sel[st_r.ldn];
                            IDX_DMA_SEL:
                                st_nxt.rdata = st_r.dma_sel[st_r.ldn];
                            default: st_nxt.rdata = 8'h00;
                        endcase
                    end
                end
            endcase
        end

        // soft reset reloads only the routing selects, after any write
        if (soft_rst) begin
            for (int d = 0; d < DEV_COUNT; d++) begin
                st_nxt.irq_sel[d] = irq_reset_value(d);
                st_nxt.dma_sel[d] = dma_reset_value(d);
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign io_rdata = st_r.rdata;

    ////////////////////////////////////////////////////////////////////////
    // base address decode

    logic [DEV_COUNT-1:0] dev_live;

    generate
        for (genvar d = 0; d < DEV_COUNT; d++) begin : g_dec
            logic [15:0] base;
            logic        upper_ok;
            assign base = {st_r.base_hi[d], st_r.base_lo[d]};
            // a zero base counts as invalid and turns the device off
            assign dev_live[d] = st_r.act[d][ACT_BIT]
                               && (base[11:0] != 12'h000);
            assign upper_ok = !st_r.osc_cfg[OSC_QUAL_BIT]
                            || (io_addr[15:12] == 4'h0);
            // eight-byte window on the low twelve bits; with the osc qualify bit set the upper four must also be zero
            assign dev_addr_hit[d] = dev_live[d] && upper_ok
                && (io_addr[11:3] == base[11:3]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // local gating

    logic [DEV_COUNT-1:0] irq_gate;
    logic [DEV_COUNT-1:0] irq_level;
    logic [DEV_COUNT-1:0] dma_gate;
    logic [DEV_COUNT-1:0] drq_level;
    logic                 floppy_dma_gate;
    logic                 parallel_irq_gate;
    logic                 parallel_service_interrupt_flag;
    logic                 parallel_dma_gate;
    logic [2:0]           ecr_mode;
    logic                 mode_forces_irq;

    assign floppy_dma_gate = floppy_controller.floppy_digital_output_reg[DOR_DMA_BIT]
                           && !floppy_controller.powered_down;
    assign parallel_irq_gate = parallel_port.ctrl[CTRL_PARALLEL_IRQ_GATE_BIT];
    assign parallel_service_interrupt_flag = parallel_port.ecr[ECR_SVC_BIT];
    assign parallel_dma_gate = parallel_port.ecr[ECR_FLOPPY_DMA_GATE_BIT];
    assign ecr_mode = parallel_port.ecr[ECR_MODE_LSB +: 3];
    assign mode_forces_irq = (ecr_mode == MODE_FIFO)
                          || (ecr_mode == MODE_ECP)
                          || (ecr_mode == MODE_TEST);

    always_comb begin
        irq_gate  = '0;
        irq_level = '0;
        dma_gate  = '0;
        drq_level = '0;
        irq_gate[DEV_FLOPPY]  = floppy_dma_gate;
        irq_level[DEV_FLOPPY] = floppy_controller.irq;
        dma_gate[DEV_FLOPPY]  = floppy_dma_gate;
        drq_level[DEV_FLOPPY] = floppy_controller.drq;

        if (parallel_port.ecp_mode) begin
            irq_gate[DEV_PARALLEL] = !parallel_service_interrupt_flag
                && (mode_forces_irq || parallel_irq_gate);
        end else begin
            irq_gate[DEV_PARALLEL] = parallel_irq_gate;
        end
        irq_level[DEV_PARALLEL] = parallel_port.irq;
        // the request pin follows the dma enable bit in every mode
        dma_gate[DEV_PARALLEL]  = parallel_dma_gate;
        drq_level[DEV_PARALLEL] = parallel_port.drq;

        // uart_aux_output_two clear keeps the line off even with interrupts enabled
        irq_gate[DEV_UART_A] = (uart_a.uart_interrupt_enable_reg[3:0] != 4'h0)
                            && uart_a.modem_control_reg[MCR_UART_AUX_OUTPUT_TWO_BIT];
        irq_level[DEV_UART_A] = uart_a.irq;
        irq_gate[DEV_UART_B] = (uart_b.uart_interrupt_enable_reg[3:0] != 4'h0)
                            && uart_b.modem_control_reg[MCR_UART_AUX_OUTPUT_TWO_BIT];
        irq_level[DEV_UART_B] = uart_b.irq;
    end

    ////////////////////////////////////////////////////////////////////////
    // routing onto system lines

    logic [IRQ_LINES-1:0] irq_avail;
    logic [IRQ_LINES-1:0] irq_used;
    logic [IRQ_LINES-1:0] irq_val;
    logic [DMA_LINES-1:0] dma_used;
    logic [DMA_LINES-1:0] dma_val;
    logic                 irq_pol_low;

    always_comb begin
        // pin mode offers PIN_IRQ_MASK, serial irq mode all lines; line 0 never, line 2 not while smi is enabled
        irq_avail = serial_irq_mode ? '1 : PIN_IRQ_MASK;
        irq_avail[0] = 1'b0;
        if (smi_enable) begin
            irq_avail[2] = 1'b0;
        end

        // devices sharing a line are or-ed onto it
        irq_used = '0;
        irq_val  = '0;
        dma_used = '0;
        dma_val  = '0;
        for (int d = 0; d < DEV_COUNT; d++) begin
            if (dev_live[d] && irq_gate[d]) begin
                irq_used = irq_used | irq_decode(st_r.irq_sel[d]);
                if (irq_level[d]) begin
                    irq_val = irq_val | irq_decode(st_r.irq_sel[d]);
                end
            end
            if (dev_live[d] && dma_gate[d]) begin
                dma_used = dma_used | dma_decode(st_r.dma_sel[d]);
                if (drq_level[d]) begin
                    dma_val = dma_val | dma_decode(st_r.dma_sel[d]);
                end
            end
        end
        irq_used = irq_used & irq_avail;
    end

    // ecp/epp parallel irq is passed through at the port's own polarity
    assign irq_pol_low = 1'b0;

    generate
        for (genvar n = 0; n < IRQ_LINES; n++) begin : g_irq
            // unused lines are released and read low
            assign irq_oe_n[n] = !irq_used[n];
            assign irq_out[n]  = irq_used[n]
                               && (irq_val[n] ^ irq_pol_low);
        end
        for (genvar c = 0; c < DMA_LINES; c++) begin : g_dma
            assign dma_oe_n[c] = !dma_used[c];
            assign dma_req[c]  = dma_used[c] && dma_val[c];
        end
    endgenerate

    // acks only reach a device whose channel is live, so gated ones ignore
    assign floppy_dma_ack = dev_live[DEV_FLOPPY] && floppy_dma_gate
        && |(dma_decode(st_r.dma_sel[DEV_FLOPPY]) & dma_ack);
    assign parallel_dma_ack = dev_live[DEV_PARALLEL] && parallel_dma_gate
        && |(dma_decode(st_r.dma_sel[DEV_PARALLEL]) & dma_ack);

    assign system_mgmt_interrupt_n = !(smi_enable && smi_request);

endmodule

/* tb/idr_router_assertions.sv */
// checker: port-level properties of the irq/dma router, bound into idr_router
`timescale 1ns/1ps
module idr_router_checker
    import idr_pkg::*;
(
    input wire logic                 mclk,
    input wire logic                 sys_rst,
    input wire idr_floppy_t          floppy_controller,
    input wire idr_parallel_t        parallel_port,
    input wire logic                 smi_enable,
    input wire logic                 smi_request,
    input wire logic                 system_mgmt_interrupt_n,
    input wire logic [IRQ_LINES-1:0] irq_out,
    input wire logic [IRQ_LINES-1:0] irq_oe_n,
    input wire logic [DMA_LINES-1:0] dma_req,
    input wire logic [DMA_LINES-1:0] dma_oe_n,
    input wire logic                 floppy_dma_ack,
    input wire logic                 parallel_dma_ack
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    smi_level_a: assert property (system_mgmt_interrupt_n ==
        !(smi_enable && smi_request)) else $error("smi output wrong level");
    irq2_smi_a: assert property (smi_enable |-> irq_oe_n[2])
        else $error("irq2 driven while smi enabled");
    irq_idle_a: assert property ((irq_out & irq_oe_n) == 16'h0000)
        else $error("undriven irq line shows a level");
    dma_idle_a: assert property ((dma_req & dma_oe_n) == 4'h0)
        else $error("undriven dma line requests");
    line_zero_a: assert property (irq_oe_n[0] && dma_oe_n[0]
        && !dma_req[0]) else $error("line zero routed");
    // a floppy that is powered down or gated must never pass an ack on
    floppy_gate_a: assert property ((!floppy_controller.floppy_digital_output_reg[3] ||
        floppy_controller.powered_down) |-> !floppy_dma_ack)
        else $error("gated floppy received dma ack");
    par_dma_a: assert property ((parallel_port.ecp_mode &&
        !parallel_port.ecr[3]) |-> !parallel_dma_ack)
        else $error("parallel ack without dma enable");
    rst_quiet_a: assert property ($fell(sys_rst) |->
        (irq_oe_n == 16'hffff && dma_oe_n == 4'hf)[*2])
        else $error("lines routed right after reset");
    smi_follow_a: assert property ($rose(smi_enable) |->
        irq_oe_n[2] ##1 (irq_oe_n[2] || !smi_enable))
        else $error("irq2 not released on smi enable");
endmodule

bind idr_router idr_router_checker idr_router_checker_i (
    .mclk(mclk), .sys_rst(sys_rst), .floppy_controller(floppy_controller),
    .parallel_port(parallel_port), .smi_enable(smi_enable),
    .smi_request(smi_request),
    .system_mgmt_interrupt_n(system_mgmt_interrupt_n),
    .irq_out(irq_out), .irq_oe_n(irq_oe_n), .dma_req(dma_req),
    .dma_oe_n(dma_oe_n), .floppy_dma_ack(floppy_dma_ack),
    .parallel_dma_ack(parallel_dma_ack));

/* tb/idr_host_model.sv */
// host dma controller model: acks a driven request promptly or slowly
`timescale 1ns/1ps
module idr_host_model (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       slow,
    input wire logic [3:0] dma_req,
    input wire logic [3:0] dma_oe_n,
    output logic     [3:0] dma_ack
);
    logic [3:0] live;
    logic [2:0] wait_r;
    // only a line that the router actually drives counts as a request
    assign live = dma_req & ~dma_oe_n;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r  <= 3'h0;
            dma_ack <= 4'h0;
        end else if (live == 4'h0) begin
            wait_r  <= 3'h0;
            dma_ack <= 4'h0;
        end else if (wait_r >= (slow ? 3'h3 : 3'h0)) begin
            dma_ack <= live;
        end else begin
            wait_r <= wait_r + 3'h1;
        end
    end
endmodule

/* tb/idr_router_tb_top.sv */
// testbench: config port accesses and routing checks for the router
`timescale 1ns/1ps
module idr_router_tb_top;
    import idr_pkg::*;
    logic          mclk, sys_rst, soft_rst, strap, io_wr, io_rd, slow;
    logic [15:0]   io_addr, port, irq_out, irq_oe_n, e;
    logic [7:0]    io_wdata, io_rdata;
    logic [5:0]    hit;
    idr_floppy_t   fl;
    idr_parallel_t pp;
    idr_uart_t     ua, ub;
    logic          sirq, smi_en, smi_req, smi_n, f_ack, p_ack;
    logic [3:0]    dma_req, dma_oe_n, dma_ack;
    int            err_total, n_checks, i;
    ////////////////////////////////////////////////////////////////////////
    idr_router idr_router_i (.mclk(mclk), .sys_rst(sys_rst),
        .soft_rst(soft_rst), .config_port_strap(strap), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .dev_addr_hit(hit), .floppy_controller(fl),
        .parallel_port(pp), .uart_a(ua), .uart_b(ub),
        .serial_irq_mode(sirq), .smi_enable(smi_en), .smi_request(smi_req),
        .system_mgmt_interrupt_n(smi_n), .irq_out(irq_out),
        .irq_oe_n(irq_oe_n), .dma_req(dma_req), .dma_oe_n(dma_oe_n),
        .dma_ack(dma_ack), .floppy_dma_ack(f_ack), .parallel_dma_ack(p_ack));
    idr_host_model idr_host_model_i (.mclk(mclk), .sys_rst(sys_rst),
        .slow(slow), .dma_req(dma_req), .dma_oe_n(dma_oe_n),
        .dma_ack(dma_ack));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        #2;
        io_addr = a; io_wdata = d; io_wr = 1'b1;
        @(posedge mclk);
        #2;
        io_wr = 1'b0;
    endtask
    task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
        wr(port, idx);
        wr(port + 16'h1, d);
    endtask
    // read data is registered, so it is sampled once the read edge landed
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        wr(port, idx);
        io_addr = port + 16'h1; io_rd = 1'b1;
        @(posedge mclk);
        #2;
        io_rd = 1'b0;
        chk("config read", {8'h00, exp}, {8'h00, io_rdata});
    endtask
    task automatic act(input logic [7:0] ldn, input logic [7:0] hi,
                       input logic [7:0] lo);
        cfg(IDX_LDN, ldn); cfg(IDX_BASE_HI, hi);
        cfg(IDX_BASE_LO, lo); cfg(IDX_ACTIVATE, 8'h01);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        err_total++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0; n_checks = 0; sys_rst = 1'b1; soft_rst = 1'b0;
        strap = 1'b0; io_wr = 1'b0; io_rd = 1'b0; io_addr = 16'h0;
        io_wdata = 8'h0; fl = '0; pp = '0; ua = '0; ub = '0; sirq = 1'b1;
        smi_en = 1'b0; smi_req = 1'b0; slow = 1'b0; port = PORT_STRAP_LO;
        repeat (5) @(posedge mclk);
        #2;
        sys_rst = 1'b0;
        @(posedge mclk);
        #2 chk("irq idle", 16'hffff, irq_oe_n);
        for (i = 0; i < 6; i++) begin
            cfg(IDX_LDN, 8'(i));
            rdchk(IDX_IRQ_SEL, i == 0 ? 8'h06 : 8'h00);
            rdchk(IDX_DMA_SEL, i == 0 ? 8'h02 :
                  (i == 3 || i == 5) ? 8'h04 : 8'h00);
        end
        cfg(IDX_PORT_LO, 8'h80);
        port = 16'h0080;
        rdchk(IDX_DMA_SEL, 8'h04);
        $display("test reset and port done");
        act(8'h03, 8'h03, 8'h78);
        io_addr = 16'h1378; #1 chk("hit 12 bit", 16'h8, {10'h0, hit});
        cfg(IDX_OSC, 8'h40);
        io_addr = 16'h1378; #1 chk("hit 16 bit", 16'h0, {10'h0, hit});
        io_addr = 16'h0378; #1 chk("hit low", 16'h8, {10'h0, hit});
        $display("test decode done");
        ua.uart_interrupt_enable_reg = 8'h01; ua.modem_control_reg = 8'h04; ua.irq = 1'b1;
        act(8'h04, 8'h02, 8'hf8);
        for (i = 1; i < 16; i++) begin
            cfg(IDX_IRQ_SEL, 8'(i));
            e = 16'h1 << i;
            chk("uart oe", ~e, irq_oe_n);
            chk("uart level", e, irq_out);
        end
        cfg(IDX_IRQ_SEL, 8'h02);
        smi_en = 1'b1; smi_req = 1'b1;
        // hold across two edges so the checker sees the enable rise
        repeat (2) @(posedge mclk);
        #3 chk("smi masks irq2", 16'hffff, irq_oe_n);
        chk("smi low", 16'h0, {15'h0, smi_n});
        smi_en = 1'b0; smi_req = 1'b0;
        #1 chk("irq2 back", 16'hfffb, irq_oe_n);
        ua.modem_control_reg = 8'h00;
        #1 chk("uart_aux_output_two clear", 16'hffff, irq_oe_n);
        ua.modem_control_reg = 8'h04; ua.uart_interrupt_enable_reg = 8'h00;
        #1 chk("ier clear", 16'hffff, irq_oe_n);
        $display("test uart irq done");
        cfg(IDX_LDN, 8'h03); cfg(IDX_IRQ_SEL, 8'h07); cfg(IDX_DMA_SEL, 8'h03);
        chk("pp parallel_irq_gate off", 16'hffff, irq_oe_n);
        pp.ctrl = 8'h10;
        #1 chk("pp parallel_irq_gate on", 16'hff7f, irq_oe_n);
        pp.ctrl = 8'h00; pp.ecp_mode = 1'b1;
        for (i = 0; i < 8; i++) begin
            pp.ecr = {3'(i), 5'h00};
            #1 chk("ecr mode", (i == 2 || i == 3 || i == 6) ?
                   16'hff7f : 16'hffff, irq_oe_n);
        end
        pp.ecr = 8'h64;
        #1 chk("service bit", 16'hffff, irq_oe_n);
        for (int s = 0; s < 2; s++) begin
            slow = 1'(s); pp.ecr = 8'h08; pp.drq = 1'b1;
            #1 chk("pp dma oe", 16'h7, {12'h0, dma_oe_n});
            chk("pp dma req", 16'h8, {12'h0, dma_req});
            for (i = 0; i < 20 && p_ack !== 1'b1; i++) @(posedge mclk);
            #1 chk("pp dma ack", 16'h1, {15'h0, p_ack});
            pp.ecr = 8'h00;
            #1 chk("pp dma off", 16'hf, {12'h0, dma_oe_n});
            @(posedge mclk);
            #2;
        end
        $display("test parallel done");
        fl.floppy_digital_output_reg = 8'h08;
        act(8'h00, 8'h03, 8'hf0);
        chk("fdc irq", 16'hffbf, irq_oe_n);
        chk("fdc dma", 16'hb, {12'h0, dma_oe_n});
        fl.powered_down = 1'b1;
        #1 chk("fdc down", 16'hffff, irq_oe_n);
        chk("fdc down dma", 16'hf, {12'h0, dma_oe_n});
        fl.powered_down = 1'b0; fl.floppy_digital_output_reg = 8'h00;
        #1 chk("fdc gate", 16'hffff, irq_oe_n);
        fl.floppy_digital_output_reg = 8'h08;
        for (i = 0; i < 8; i++) begin
            cfg(IDX_DMA_SEL, 8'(i));
            e = (i >= 1 && i <= 3) ? ~(16'h1 << i) : 16'hffff;
            chk("dma select", e & 16'hf, {12'h0, dma_oe_n});
        end
        cfg(IDX_IRQ_SEL, 8'h09);
        @(posedge mclk);
        #2;
        soft_rst = 1'b1;
        @(posedge mclk);
        #2;
        soft_rst = 1'b0;
        rdchk(IDX_IRQ_SEL, 8'h06);
        rdchk(IDX_DMA_SEL, 8'h02);
        fl.drq = 1'b1; slow = 1'b0;
        repeat (2) @(posedge mclk);
        #2 chk("fdc dma req", 16'h4, {12'h0, dma_req});
        chk("fdc dma ack", 16'h1, {15'h0, f_ack});
        fl.powered_down = 1'b1;
        #1 chk("fdc ack off", 16'h0, {15'h0, f_ack});
        $display("test floppy and soft reset done");
        // a mid-run hard reset with the strap high moves the port
        strap = 1'b1; sys_rst = 1'b1;
        repeat (5) @(posedge mclk);
        #2 sys_rst = 1'b0;
        port = PORT_STRAP_HI;
        rdchk(IDX_IRQ_SEL, 8'h06);
        rdchk(IDX_DMA_SEL, 8'h02);
        chk("reset idle", 16'hffff, irq_oe_n);
        $display("test strap reset done");
        final_report();
    end
endmodule
